// File: src/lbp_fifo.sv
module lbp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rp_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: src/lbp_pkg.sv
package lbp_pkg;
   // processor bus variants
   typedef enum logic [1:0] {
      LBP_VAR_A,
      LBP_VAR_B,
      LBP_VAR_C
   } lbp_variant_t;

   localparam int LBP_AW            = 32;
   localparam int LBP_DW            = 32;
   localparam int LBP_FIFO_DEPTH    = 8;
   localparam int LBP_MAX_RETRY     = 2;
   localparam int LBP_REG_RD_CLKS   = 3;
   localparam int LBP_REG_WR_CLKS   = 6;
   localparam int LBP_WS_ONE        = 1;
   localparam int LBP_WS_TWO        = 2;
   localparam int LBP_ALIGN_BITS    = 4;
   localparam int LBP_CNT_W         = 4;
   localparam logic [1:0] LBP_RETRY_RST = 2'h0;
endpackage

// File: src/lbp_port.sv
// Function
// - wait for other master to drop busy/grant-ack before driving cycles
// - master single reads and writes finish without slave wait states
// - address lines are not examined during dma cycles
// - low lane acknowledge never asserted in dma when 16-bit off
// - dual-address dma always ends normally, no retry or bus error
// - low lane acknowledge unused for dma unless on a 16-bit port
// - variant b unaligned burst write gets at least one wait state
// - variant c unaligned burst read/write gets wait states
// - variant b dma ignores transfer-done input
// - at most two consecutive retries on register access
// - register ack no sooner than three clocks read, six write
// - slave wait states: one for retry/burst/posted, two delayed single
module lbp_port
   import lbp_pkg::*;
#(
   parameter int AW    = LBP_AW,
   parameter int DW    = LBP_DW,
   parameter int DEPTH = LBP_FIFO_DEPTH
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire lbp_variant_t  bus_variant,
   input  wire logic          sixteen_bit_port_setting,
   // ****************
   // master request side
   // ****************
   input  wire logic          mst_req,
   input  wire logic          mst_write,
   input  wire logic          mst_last,
   input  wire logic [AW-1:0] mst_addr,
   input  wire logic [DW-1:0] mst_wdata,
   output logic               mst_ready,
   output logic               mst_done,
   input  wire logic          bus_busy_in,
   input  wire logic          grant_ack_in,
   output logic               bus_busy_o,
   output logic               bus_busy_oe,
   output logic               addr_ctl_oe,
   output logic [AW-1:0]      addr_o,
   output logic               write_o,
   output logic               transfer_start_strobe_n,
   output logic [DW-1:0]      data_o,
   // ****************
   // slave side
   // ****************
   input  wire logic          slv_start,
   input  wire logic          slv_write,
   input  wire logic          slv_burst,
   input  wire logic          slv_reg,
   input  wire logic          slv_delayed,
   input  wire logic          slv_retry_req,
   input  wire logic          slv_dma,
   input  wire logic          slv_dual,
   input  wire logic          slv_fast,
   input  wire logic [AW-1:0] slv_addr,
   input  wire logic [DW-1:0] slv_wdata,
   input  wire logic          transfer_done_in,
   output logic               transfer_acknowledge_line_n,
   output logic               low_lane_acknowledge_n,
   output logic               high_lane_acknowledge_n,
   output logic               retry_n,
   output logic               bus_error_line_n,
   output logic               dma_done_seen,
   // ****************
   // write data stream
   // ****************
   output logic               wr_valid,
   input  wire logic          wr_ready,
   output logic [DW-1:0]      wr_data
);
   // ****************
   // pin synchronisers
   // ****************
   logic [1:0] bb_sync_ff;
   logic [1:0] ga_sync_ff;
   logic [1:0] td_sync_ff;
   logic       other_busy;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bb_sync_ff <= 2'h0;
         ga_sync_ff <= 2'h0;
         td_sync_ff <= 2'h0;
      end else begin
         bb_sync_ff <= {bb_sync_ff[0], bus_busy_in};
         ga_sync_ff <= {ga_sync_ff[0], grant_ack_in};
         td_sync_ff <= {td_sync_ff[0], transfer_done_in};
      end
   end
   assign other_busy = bb_sync_ff[1] || ga_sync_ff[1];

   // ****************
   // master
   // ****************
   typedef enum logic [1:0] {LBP_M_IDLE, LBP_M_WAIT, LBP_M_XFER} lbp_mst_t;
   lbp_mst_t m_state_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         m_state_ff              <= LBP_M_IDLE;
         bus_busy_o              <= 1'b0;
         bus_busy_oe             <= 1'b0;
         addr_ctl_oe             <= 1'b0;
         addr_o                  <= '0;
         write_o                 <= 1'b0;
         data_o                  <= '0;
         transfer_start_strobe_n <= 1'b1;
         mst_done                <= 1'b0;
         mst_ready               <= 1'b0;
      end else begin
         mst_done                <= 1'b0;
         mst_ready               <= 1'b0;
         transfer_start_strobe_n <= 1'b1;
         unique case (m_state_ff)
            LBP_M_IDLE: begin
               if (mst_req) begin
                  m_state_ff <= LBP_M_WAIT;
               end
            end
            LBP_M_WAIT: begin
               if (!other_busy) begin
                  m_state_ff              <= LBP_M_XFER;
                  bus_busy_o              <= 1'b1;
                  bus_busy_oe             <= 1'b1;
                  addr_ctl_oe             <= 1'b1;
                  addr_o                  <= mst_addr;
                  write_o                 <= mst_write;
                  data_o                  <= mst_wdata;
                  transfer_start_strobe_n <= 1'b0;
                  mst_ready               <= 1'b1;
               end
            end
            LBP_M_XFER: begin
               // single cycle, no slave wait states needed
               mst_done <= 1'b1;
               if (mst_last || !mst_req) begin
                  m_state_ff  <= LBP_M_IDLE;
                  bus_busy_o  <= 1'b0;
                  bus_busy_oe <= 1'b0;
                  addr_ctl_oe <= 1'b0;
               end else begin
                  addr_o                  <= mst_addr;
                  write_o                 <= mst_write;
                  data_o                  <= mst_wdata;
                  transfer_start_strobe_n <= 1'b0;
                  mst_ready               <= 1'b1;
               end
            end
            default: m_state_ff <= LBP_M_IDLE;
         endcase
      end
   end

   // ****************
   // slave
   // ****************
   typedef enum logic [1:0] {LBP_S_IDLE, LBP_S_WAIT, LBP_S_ACK} lbp_slv_t;
   lbp_slv_t           s_state_ff;
   logic [LBP_CNT_W-1:0] s_cnt_ff;
   logic [LBP_CNT_W-1:0] nxt_wait;
   logic [1:0]         retry_cnt_ff;
   logic               s_retry_ff;
   logic               s_dma_ff;
   logic               s_wr_ff;
   logic [DW-1:0]      s_wdata_ff;
   logic               unaligned;
   logic               do_retry;
   logic               fifo_in_ready;

   // address is not looked at in dma cycles
   assign unaligned = !slv_dma && (slv_addr[LBP_ALIGN_BITS-1:0] != '0);
   // retries on register access stop after two in a row
   assign do_retry = slv_retry_req && !slv_dual
                     && !(slv_reg && retry_cnt_ff >= 2'(LBP_MAX_RETRY));

   always_comb begin
      nxt_wait = LBP_CNT_W'(LBP_WS_ONE);
      if (slv_dma) begin
         nxt_wait = slv_fast ? '0 : LBP_CNT_W'(LBP_WS_ONE);
      end else if (do_retry) begin
         nxt_wait = LBP_CNT_W'(LBP_WS_ONE);
      end else if (slv_reg) begin
         nxt_wait = slv_write ? LBP_CNT_W'(LBP_REG_WR_CLKS - 1)
                              : LBP_CNT_W'(LBP_REG_RD_CLKS - 1);
      end else if (slv_burst && unaligned
                   && bus_variant != LBP_VAR_A) begin
         nxt_wait = LBP_CNT_W'(LBP_WS_TWO);
      end else if (slv_delayed && !slv_burst) begin
         nxt_wait = LBP_CNT_W'(LBP_WS_TWO);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_state_ff   <= LBP_S_IDLE;
         s_cnt_ff     <= '0;
         s_retry_ff   <= 1'b0;
         s_dma_ff     <= 1'b0;
         s_wr_ff      <= 1'b0;
         s_wdata_ff   <= '0;
         retry_cnt_ff <= LBP_RETRY_RST;
      end else begin
         unique case (s_state_ff)
            LBP_S_IDLE: begin
               if (slv_start) begin
                  s_state_ff <= LBP_S_WAIT;
                  s_cnt_ff   <= nxt_wait;
                  s_retry_ff <= do_retry;
                  s_dma_ff   <= slv_dma;
                  s_wr_ff    <= slv_write && !do_retry;
                  s_wdata_ff <= slv_wdata;
                  if (slv_reg) begin
                     retry_cnt_ff <= do_retry ? retry_cnt_ff + 2'h1
                                              : LBP_RETRY_RST;
                  end
               end
            end
            LBP_S_WAIT: begin
               // write data must fit in the fifo before acking
               if (s_cnt_ff != '0) begin
                  s_cnt_ff <= s_cnt_ff - 1'b1;
               end else if (!s_wr_ff || fifo_in_ready) begin
                  s_state_ff <= LBP_S_ACK;
               end
            end
            LBP_S_ACK: s_state_ff <= LBP_S_IDLE;
            default:   s_state_ff <= LBP_S_IDLE;
         endcase
      end
   end

   logic ack_now;
   assign ack_now = (s_state_ff == LBP_S_WAIT) && (s_cnt_ff == '0)
                    && (!s_wr_ff || fifo_in_ready);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         transfer_acknowledge_line_n <= 1'b1;
         high_lane_acknowledge_n     <= 1'b1;
         low_lane_acknowledge_n      <= 1'b1;
         retry_n                     <= 1'b1;
         bus_error_line_n            <= 1'b1;
      end else begin
         transfer_acknowledge_line_n <= !(ack_now && !s_retry_ff);
         high_lane_acknowledge_n     <= !(ack_now && !s_retry_ff);
         low_lane_acknowledge_n      <= !(ack_now && !s_retry_ff
            && !(s_dma_ff && !sixteen_bit_port_setting));
         retry_n                     <= !(ack_now && s_retry_ff);
         bus_error_line_n            <= 1'b1;
      end
   end

   // done input only honoured outside variant b
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dma_done_seen <= 1'b0;
      end else begin
         dma_done_seen <= s_dma_ff && td_sync_ff[1]
                          && bus_variant != LBP_VAR_B;
      end
   end

   lbp_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      // push only at the ack, so a full fifo stalls the ack, not the data
      .in_valid  (ack_now && s_wr_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (s_wdata_ff),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_data)
   );

   // ****************
   // checks
   // ****************
   a_release_bus: assert property (@(posedge clk) disable iff (!rst_n)
      (m_state_ff == LBP_M_XFER && mst_last) |=> !bus_busy_oe && !addr_ctl_oe)
      else $error("bus not released");
   a_no_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
      (m_state_ff == LBP_M_WAIT && other_busy) |=> transfer_start_strobe_n)
      else $error("start while other master busy");
   a_master_done: assert property (@(posedge clk) disable iff (!rst_n)
      !transfer_start_strobe_n |=> mst_done)
      else $error("master cycle stalled");
   a_no_bus_err: assert property (@(posedge clk) disable iff (!rst_n)
      bus_error_line_n)
      else $error("bus error driven");
   a_low_lane_off: assert property (@(posedge clk) disable iff (!rst_n)
      (s_dma_ff && !sixteen_bit_port_setting && s_state_ff == LBP_S_ACK)
      |-> low_lane_acknowledge_n)
      else $error("low lane acked in dma");
   a_reg_read_min: assert property (@(posedge clk) disable iff (!rst_n)
      (slv_start && s_state_ff == LBP_S_IDLE && slv_reg && !slv_write
       && !do_retry && !slv_dma) |-> ##1 transfer_acknowledge_line_n [*3])
      else $error("register read acked early");
   a_reg_write_min: assert property (@(posedge clk) disable iff (!rst_n)
      (slv_start && s_state_ff == LBP_S_IDLE && slv_reg && slv_write
       && !do_retry && !slv_dma) |-> ##1 transfer_acknowledge_line_n [*6])
      else $error("register write acked early");
   a_retry_limit: assert property (@(posedge clk) disable iff (!rst_n)
      retry_cnt_ff <= 2'(LBP_MAX_RETRY))
      else $error("too many register retries");
   a_unaligned_ws: assert property (@(posedge clk) disable iff (!rst_n)
      (slv_start && s_state_ff == LBP_S_IDLE && slv_burst && unaligned
       && bus_variant == LBP_VAR_B && !do_retry)
      |-> ##1 transfer_acknowledge_line_n [*2])
      else $error("unaligned burst without wait");
   a_done_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      bus_variant == LBP_VAR_B |=> !dma_done_seen)
      else $error("done honoured on variant b");
endmodule

// File: testbench/lbp_partner.sv
// ****************
// far-side processor model
// ****************
module lbp_partner (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       hold_req,
   input  wire logic [7:0] hold_len,
   output logic            bus_busy_in,
   output logic            grant_ack_in,
   output logic            transfer_done_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int left;
   // another master owns the bus for hold_len cycles, then lets go
   always @(posedge clk) begin
      if (!rst_n) left <= 0;
      else if (hold_req) left <= hold_len;
      else if (left > 0) left <= left - 1;
   end
   assign bus_busy_in  = left > 0;
   assign grant_ack_in = left > 1;
   // toggles every cycle so an input that must be ignored really moves
   always @(posedge clk) begin
      if (!rst_n) transfer_done_in <= 1'b0;
      else transfer_done_in <= ~transfer_done_in;
   end
endmodule

// File: testbench/test_lbp_port.sv
module test_lbp_port;
   import lbp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, sixteen_bit_port_setting = 0;
   lbp_variant_t bus_variant = LBP_VAR_A;
   logic mst_req = 0, mst_write = 0, mst_last = 0, hold_req = 0;
   logic [31:0] mst_addr = '0, mst_wdata = '0, slv_addr = '0, slv_wdata = '0;
   logic slv_start = 0, slv_write = 0, slv_burst = 0, slv_reg = 0;
   logic slv_delayed = 0, slv_retry_req = 0, slv_dma = 0, slv_dual = 0;
   logic slv_fast = 0, wr_ready = 0, in_dma = 0;
   logic mst_ready, mst_done, bus_busy_in, grant_ack_in, bus_busy_o;
   logic bus_busy_oe, addr_ctl_oe, write_o, transfer_start_strobe_n;
   logic transfer_done_in, transfer_acknowledge_line_n, retry_n;
   logic low_lane_acknowledge_n, high_lane_acknowledge_n;
   logic bus_error_line_n, dma_done_seen, wr_valid;
   logic [31:0] addr_o, data_o, wr_data, st = 32'h00005c29;
   int miscompares = 0, n_compared = 0, base, cyc;
   logic rt;
   logic [31:0] q[$];
   always #2 clk = ~clk;
   lbp_port dut (.clk(clk), .rst_n(rst_n), .bus_variant(bus_variant),
      .sixteen_bit_port_setting(sixteen_bit_port_setting),
      .mst_req(mst_req), .mst_write(mst_write), .mst_last(mst_last),
      .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_ready(mst_ready),
      .mst_done(mst_done), .bus_busy_in(bus_busy_in),
      .grant_ack_in(grant_ack_in), .bus_busy_o(bus_busy_o),
      .bus_busy_oe(bus_busy_oe), .addr_ctl_oe(addr_ctl_oe),
      .addr_o(addr_o), .write_o(write_o), .data_o(data_o),
      .transfer_start_strobe_n(transfer_start_strobe_n),
      .slv_start(slv_start), .slv_write(slv_write), .slv_burst(slv_burst),
      .slv_reg(slv_reg), .slv_delayed(slv_delayed), .slv_dma(slv_dma),
      .slv_retry_req(slv_retry_req), .slv_dual(slv_dual),
      .slv_fast(slv_fast), .slv_addr(slv_addr), .slv_wdata(slv_wdata),
      .transfer_done_in(transfer_done_in), .retry_n(retry_n),
      .transfer_acknowledge_line_n(transfer_acknowledge_line_n),
      .low_lane_acknowledge_n(low_lane_acknowledge_n),
      .high_lane_acknowledge_n(high_lane_acknowledge_n),
      .bus_error_line_n(bus_error_line_n), .dma_done_seen(dma_done_seen),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
   lbp_partner far (.clk(clk), .rst_n(rst_n), .hold_req(hold_req),
      .hold_len(8'h0a), .bus_busy_in(bus_busy_in),
      .grant_ack_in(grant_ack_in), .transfer_done_in(transfer_done_in));
   // ****************
   // shared helpers
   // ****************
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   int rcnt = 0, dd = 0, strobes = 0;
   logic [31:0] ea, ed;
   logic ew, prev_st = 1'b1;
   // ****************
   // monitors
   // ****************
   always @(posedge clk) begin
      ea <= mst_addr;
      ed <= mst_wdata;
      ew <= mst_write;
      wr_ready <= ^xs();
   end
   always @(negedge clk) begin
      if (!rst_n) begin
         prev_st = 1'b1;
      end else begin
         if (wr_valid && wr_ready) begin
            if (q.size() == 0) check("fifo empty", 1, 0);
            else check("wr_data", wr_data, q.pop_front());
         end
         if (dma_done_seen) dd++;
         if (!transfer_start_strobe_n) begin
            strobes++;
            check("addr_o", addr_o, ea);
            check("data_o", data_o, ed);
            check("write_o", write_o, ew);
            check("mst_ready", mst_ready, 1);
            check("driving", {bus_busy_o, bus_busy_oe, addr_ctl_oe}, 7);
            check("other free", bus_busy_in || grant_ack_in, 0);
         end
         check("mst_done", mst_done, !prev_st);
         prev_st = transfer_start_strobe_n;
      end
   end
   // ****************
   // scenarios
   // ****************
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      mst_req <= 1'b0;
      slv_start <= 1'b0;
      hold_req <= 1'b0;
      q.delete();
      rcnt = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check("reset outs", {transfer_acknowledge_line_n, retry_n,
         transfer_start_strobe_n, bus_busy_oe, addr_ctl_oe, wr_valid}, 56);
   endtask
   // one slave access; wait states from the rules, integers only
   task automatic slv(logic wr, burst, rg, dly, rty, dma, dual, fast);
      logic [31:0] a, d;
      int w;
      logic eff, full;
      a = xs();
      d = xs();
      eff = rty && !dual && !(rg && rcnt >= LBP_MAX_RETRY);
      if (rg) rcnt = eff ? rcnt + 1 : 0;
      if (dma) w = fast ? 0 : 1;
      else if (eff) w = 1;
      else if (rg) w = wr ? LBP_REG_WR_CLKS - 1 : LBP_REG_RD_CLKS - 1;
      else if (burst && a[3:0] != 0 && bus_variant != LBP_VAR_A) w = 2;
      else if (dly && !burst) w = 2;
      else w = 1;
      @(posedge clk);
      slv_start <= 1'b1;
      slv_write <= wr;
      slv_burst <= burst;
      slv_reg <= rg;
      slv_delayed <= dly;
      slv_retry_req <= rty;
      slv_dma <= dma;
      slv_dual <= dual;
      slv_fast <= fast;
      slv_addr <= a;
      slv_wdata <= d;
      @(posedge clk);
      slv_start <= 1'b0;
      full = (q.size() >= LBP_FIFO_DEPTH);
      if (wr && !eff) q.push_back(d);
      cyc = 0;
      dd = 0;
      do begin
         @(negedge clk);
         cyc++;
      end while (transfer_acknowledge_line_n && retry_n && cyc < 40);
      if (full && wr && !eff) check("ack late", cyc >= w + 2, 1);
      else check("ack wait", cyc, w + 2);
      check("retry", !retry_n, eff);
      check("high lane", high_lane_acknowledge_n, eff);
      check("low lane", low_lane_acknowledge_n,
            eff || (dma && !sixteen_bit_port_setting));
      check("bus error", bus_error_line_n, 1);
      if (dma) begin
         repeat (3) @(negedge clk);
         check("done seen", dd > 0, bus_variant != LBP_VAR_B);
      end
   endtask
   task automatic mst(logic use_last);
      int k, t;
      k = strobes;
      @(posedge clk);
      hold_req <= 1'b1;
      @(posedge clk);
      hold_req <= 1'b0;
      repeat (3) @(posedge clk);
      mst_req <= 1'b1;
      t = 0;
      while (strobes < k + 3 && t < 60) begin
         @(posedge clk);
         mst_addr <= xs();
         mst_wdata <= xs();
         mst_write <= ^xs();
         t++;
      end
      if (use_last) begin
         mst_last <= 1'b1;
         @(posedge clk);
         mst_last <= 1'b0;
      end
      mst_req <= 1'b0;
      repeat (4) @(negedge clk);
      check("released", {bus_busy_oe, addr_ctl_oe}, 0);
      check("cycles", strobes >= k + 3, 1);
   endtask
   initial begin
      logic [31:0] f;
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      logic [31:0] f;
      do_reset();
      for (int v = 0; v < 6; v++) begin
         @(posedge clk);
         bus_variant <= lbp_variant_t'(v % 3);
         sixteen_bit_port_setting <= v[0];
         repeat (3) slv(0, 0, 1, 0, 1, 0, 0, 0);
         slv(1, 0, 1, 0, 0, 0, 0, 0);
         slv(1, 1, 0, 0, 0, 0, 0, 0);
         slv(0, 0, 0, 1, 1, 1, 1, 0);
         for (int i = 0; i < 30; i++) begin
            f = xs();
            slv(f[0], f[1], f[2] & !f[5], f[3], f[4], f[5], f[6] & f[5],
                f[7] & f[5]);
         end
         mst(v[0]);
         if (v == 2) do_reset();
      end
      results();
   end
endmodule
